// ### hdl/tncr_top.sv
// command chaining, completion status and reset control with ahb-lite register slave
//
// The AHB-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/10ps
module tncr_top (
    // clock, reset, enable
    input  wire logic        i_sys_clk,
    input  wire logic        i_srst,
    input  wire logic        i_ce,
    input  wire logic        i_hw_reset_n,
    // ahb-lite slave
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic [31:0]      o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    // transmit engine side
    input  wire logic        i_token,
    input  wire logic        i_tx_done,
    input  wire logic        i_tx_acked,
    output logic             o_tx_start,
    output logic             o_tx_abort,
    output logic [2:0]       o_tx_page,
    output logic             o_tx_enable,
    // receive engine side
    input  wire logic        i_rx_start,
    input  wire logic        i_rx_done,
    output logic             o_rx_armed,
    output logic [2:0]       o_rx_page,
    // packet ram write port
    output logic             o_ram_we,
    output logic [10:0]      o_ram_addr,
    output logic [7:0]       o_ram_wdata,
    // core status
    output logic             o_core_rst,
    output logic             o_core_awake,
    output logic             o_irq
);
    logic       hw_rst;
    logic       cfg_rst;
    logic       core_rst;
    // registers
    logic [7:0] cfg_q;
    logic [7:0] setup_q;
    logic [7:0] node_q;
    logic [1:0] mask_q;
    // bus data phase
    logic       wr_q;
    logic [7:0] wa_q;
    logic [31:0] rd_q;
    // transmit queue and results
    logic [1:0] tq_v_q;
    logic [5:0] tq_pg_q;
    logic       tx_act_q;
    logic [1:0] tr_v_q;
    logic [5:0] tr_pl_q;
    logic [1:0] tgap_q;
    logic       ack_live_q;
    // receive queue and results
    logic [1:0] rq_v_q;
    logic [5:0] rq_pg_q;
    logic       rx_act_q;
    logic [1:0] rr_v_q;
    logic [5:0] rr_pl_q;
    logic [1:0] rgap_q;
    // interrupt
    logic       irq_q;
    logic [1:0] igap_q;
    // wake-up sequencer and transmit engine strobes
    tncr_pkg::tncr_nid_e nid_q;
    logic       tx_start_q;
    logic       tx_abort_q;
    logic [2:0] tx_page_q;
    logic       ram_we_q;
    logic [10:0] ram_addr_q;
    logic [7:0] ram_wdata_q;

    // hardware reset pin filter
    tncr_rst_filter u_filt (
        .i_sys_clk    (i_sys_clk),
        .i_srst       (i_srst),
        .i_ce         (i_ce),
        .i_hw_reset_n (i_hw_reset_n),
        .o_hw_rst     (hw_rst)
    );

    // soft reset spares the config and setup registers
    assign cfg_rst  = i_srst || hw_rst;
    assign core_rst = cfg_rst || cfg_q[tncr_pkg::CFG_SRST_BIT];

    // bus address phase decode
    logic       ap_valid;
    logic       ap_wr;
    logic [7:0] ap_addr;
    assign ap_valid = i_hsel && i_hready && i_ce && (i_htrans == tncr_pkg::HTRANS_NONSEQ);
    assign ap_wr    = ap_valid && i_hwrite;
    assign ap_addr  = {i_haddr[7:2], 2'h0};

    // data phase write strobes
    logic       wr_cfg;
    logic       wr_cmd;
    logic       wr_mask;
    logic       wr_setup;
    logic       wr_node;
    logic [2:0] cmd_code;
    logic [2:0] cmd_page;
    assign wr_cfg   = wr_q && (wa_q == tncr_pkg::REG_CFG);
    assign wr_cmd   = wr_q && (wa_q == tncr_pkg::REG_CMD) && !core_rst;
    assign wr_mask  = wr_q && (wa_q == tncr_pkg::REG_MASK) && !core_rst;
    assign wr_setup = wr_q && (wa_q == tncr_pkg::REG_SETUP);
    assign wr_node  = wr_q && (wa_q == tncr_pkg::REG_NODEID) && !core_rst;
    assign cmd_code = i_hwdata[tncr_pkg::CMD_CODE_LSB +: 3];
    assign cmd_page = i_hwdata[tncr_pkg::CMD_PAGE_LSB +: 3];

    // command decode
    logic chain;
    logic c_txen;
    logic c_rxen;
    logic c_txdis;
    logic c_rxdis;
    logic c_clrt;
    logic c_clrr;
    assign chain   = cfg_q[tncr_pkg::CFG_CHAIN_BIT];
    assign c_txen  = wr_cmd && (cmd_code == tncr_pkg::CMD_TX_EN);
    assign c_rxen  = wr_cmd && (cmd_code == tncr_pkg::CMD_RX_EN);
    assign c_txdis = wr_cmd && (cmd_code == tncr_pkg::CMD_TX_DIS);
    assign c_rxdis = wr_cmd && (cmd_code == tncr_pkg::CMD_RX_DIS);
    assign c_clrt  = wr_cmd && (cmd_code == tncr_pkg::CMD_CLR_TXI);
    assign c_clrr  = wr_cmd && (cmd_code == tncr_pkg::CMD_CLR_RXI);

    // occupancy counts
    logic [1:0] tq_n;
    logic [1:0] tr_n;
    logic [1:0] rq_n;
    logic [1:0] rr_n;
    assign tq_n = {1'b0, tq_v_q[0]} + {1'b0, tq_v_q[1]};
    assign tr_n = {1'b0, tr_v_q[0]} + {1'b0, tr_v_q[1]};
    assign rq_n = {1'b0, rq_v_q[0]} + {1'b0, rq_v_q[1]};
    assign rr_n = {1'b0, rr_v_q[0]} + {1'b0, rr_v_q[1]};

    // transmit queue events; when chaining, capacity counts held results so a result always has room
    logic t_done;
    logic t_push;
    logic t_start;
    logic t_can0;
    logic t_can1;
    logic [1:0] t_keep;
    logic [7:0] tq_nx;
    assign t_done  = i_tx_done && tx_act_q && tq_v_q[0];
    assign t_push  = c_txen && (chain ? ((tq_n + tr_n) < 2'h2) : (tq_n == 2'h0));
    assign t_can0  = c_txdis && tq_v_q[0] && !t_done;
    assign t_can1  = c_txdis && tq_v_q[1] && t_done;
    assign t_start = i_token && tq_v_q[0] && !tx_act_q && o_tx_enable && !t_can0;
    assign t_keep  = {tq_v_q[1] && !t_can1, tq_v_q[0] && !t_done && !t_can0};
    assign tq_nx   = tncr_pkg::tncr_q_next(t_keep, tq_pg_q, t_push, cmd_page);

    // transmit results: pop on clear only when one is held, then append completion
    logic       tr_pop;
    logic       tr_push;
    logic [7:0] tr_nx;
    assign tr_pop  = c_clrt && tr_v_q[0];
    assign tr_push = t_done && chain;
    assign tr_nx   = tncr_pkg::tncr_q_next({tr_v_q[1], tr_v_q[0] && !tr_pop}, tr_pl_q,
                                           tr_push, {2'h0, i_tx_acked});

    // receive queue events
    logic r_done;
    logic r_push;
    logic r_can0;
    logic r_can1;
    logic [1:0] r_keep;
    logic [7:0] rq_nx;
    assign r_done = i_rx_done && rx_act_q && rq_v_q[0];
    assign r_push = c_rxen && (chain ? ((rq_n + rr_n) < 2'h2) : (rq_n == 2'h0));
    assign r_can0 = c_rxdis && rq_v_q[0] && !rx_act_q;
    assign r_can1 = c_rxdis && rq_v_q[1] && rx_act_q;
    assign r_keep = {rq_v_q[1] && !r_can1, rq_v_q[0] && !r_done && !r_can0};
    assign rq_nx  = tncr_pkg::tncr_q_next(r_keep, rq_pg_q, r_push, cmd_page);

    // receive results carry the page that was filled
    logic       rr_pop;
    logic       rr_push;
    logic [7:0] rr_nx;
    assign rr_pop  = c_clrr && rr_v_q[0];
    assign rr_push = r_done && chain;
    assign rr_nx   = tncr_pkg::tncr_q_next({rr_v_q[1], rr_v_q[0] && !rr_pop}, rr_pl_q,
                                           rr_push, rq_pg_q[2:0]);

    // visible flags; a promoted second result stays hidden for the gap time
    logic tx_free;
    logic tx_ack;
    logic rx_idle;
    logic tx_ev;
    logic rx_ev;
    assign tx_free = !tq_v_q[0];
    assign rx_idle = !rq_v_q[0];
    assign tx_ev   = tr_v_q[0] && (tgap_q == 2'h0);
    assign rx_ev   = rr_v_q[0] && (rgap_q == 2'h0);
    assign tx_ack  = chain ? (tx_ev && tr_pl_q[0]) : ack_live_q;

    // interrupt source select and inactive gap
    logic irq_raw;
    logic irq_d;
    assign irq_raw = chain ? ((tx_ev && mask_q[tncr_pkg::MASK_TX]) || (rx_ev && mask_q[tncr_pkg::MASK_RX])) :
                             ((tx_free && mask_q[tncr_pkg::MASK_TX]) || (rx_idle && mask_q[tncr_pkg::MASK_RX]));
    assign irq_d   = irq_raw && (irq_q || (igap_q == 2'h0));

    // read data selection
    logic [31:0] stat_w;
    logic [31:0] queue_w;
    logic [31:0] rd_d;
    assign stat_w  = 32'(({o_core_awake, chain, rx_ev, tx_ev, rx_idle, tx_ack, tx_free}));
    assign queue_w = 32'({1'b0, rq_pg_q[2:0], 1'b0, tq_pg_q[2:0], rr_v_q, tr_v_q, rq_v_q, tq_v_q});
    assign rd_d    = (ap_addr == tncr_pkg::REG_CFG)    ? {24'h0, cfg_q}   :
                     (ap_addr == tncr_pkg::REG_STAT)   ? stat_w           :
                     (ap_addr == tncr_pkg::REG_MASK)   ? {30'h0, mask_q}  :
                     (ap_addr == tncr_pkg::REG_SETUP)  ? {24'h0, setup_q} :
                     (ap_addr == tncr_pkg::REG_NODEID) ? {24'h0, node_q}  :
                     (ap_addr == tncr_pkg::REG_QUEUE)  ? queue_w          :
                     (ap_addr == tncr_pkg::REG_RESPG)  ? {29'h0, rr_pl_q[2:0]} : 32'h0;

    // bus data phase capture
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            wr_q <= 1'b0;
            wa_q <= 8'h0;
            rd_q <= 32'h0;
        end else if (i_ce) begin
            wr_q <= ap_wr;
            wa_q <= ap_addr;
            if (ap_valid && !i_hwrite) begin
                rd_q <= rd_d;
            end
        end
    end

    // config and setup survive the soft reset
    always_ff @(posedge i_sys_clk) begin
        if (cfg_rst) begin
            cfg_q   <= tncr_pkg::CFG_RST;
            setup_q <= tncr_pkg::SETUP_RST;
        end else if (i_ce) begin
            if (wr_cfg) begin
                cfg_q <= i_hwdata[7:0];
            end
            if (wr_setup) begin
                setup_q <= i_hwdata[7:0];
            end
        end
    end

    // node id and mask registers
    always_ff @(posedge i_sys_clk) begin
        if (core_rst) begin
            node_q <= tncr_pkg::NODE_RST;
            mask_q <= tncr_pkg::MASK_RST;
        end else if (i_ce) begin
            if (wr_node) begin
                node_q <= i_hwdata[7:0];
            end
            if (wr_mask) begin
                mask_q <= i_hwdata[1:0];
            end
        end
    end

    // transmit queue, results and live ack
    always_ff @(posedge i_sys_clk) begin
        if (core_rst) begin
            tq_v_q     <= 2'h0;
            tq_pg_q    <= 6'h0;
            tx_act_q   <= 1'b0;
            tr_v_q     <= 2'h0;
            tr_pl_q    <= 6'h0;
            tgap_q     <= 2'h0;
            ack_live_q <= 1'b0;
        end else if (i_ce) begin
            tq_v_q   <= tq_nx[7:6];
            tq_pg_q  <= tq_nx[5:0];
            tx_act_q <= t_keep[0] && (tx_act_q || t_start);
            tr_v_q   <= tr_nx[7:6];
            tr_pl_q  <= tr_nx[5:0];
            tgap_q   <= tr_pop ? tncr_pkg::GAP_LOAD : (tgap_q != 2'h0) ? tgap_q - 2'h1 : 2'h0;
            if (t_done) begin
                ack_live_q <= i_tx_acked;
            end else if (t_push) begin
                ack_live_q <= 1'b0;
            end
        end
    end

    // receive queue and results
    always_ff @(posedge i_sys_clk) begin
        if (core_rst) begin
            rq_v_q   <= 2'h0;
            rq_pg_q  <= 6'h0;
            rx_act_q <= 1'b0;
            rr_v_q   <= 2'h0;
            rr_pl_q  <= 6'h0;
            rgap_q   <= 2'h0;
        end else if (i_ce) begin
            rq_v_q   <= rq_nx[7:6];
            rq_pg_q  <= rq_nx[5:0];
            rx_act_q <= r_keep[0] && (rx_act_q || i_rx_start);
            rr_v_q   <= rr_nx[7:6];
            rr_pl_q  <= rr_nx[5:0];
            rgap_q   <= rr_pop ? tncr_pkg::GAP_LOAD : (rgap_q != 2'h0) ? rgap_q - 2'h1 : 2'h0;
        end
    end

    // interrupt output with minimum low time
    always_ff @(posedge i_sys_clk) begin
        if (core_rst) begin
            irq_q  <= 1'b0;
            igap_q <= 2'h0;
        end else if (i_ce) begin
            irq_q  <= irq_d;
            igap_q <= (irq_q && !irq_d) ? tncr_pkg::GAP_LOAD :
                      (igap_q != 2'h0) ? igap_q - 2'h1 : 2'h0;
        end
    end

    // transmit engine strobes
    always_ff @(posedge i_sys_clk) begin
        if (core_rst) begin
            tx_start_q <= 1'b0;
            tx_abort_q <= 1'b0;
            tx_page_q  <= 3'h0;
        end else if (i_ce) begin
            tx_start_q <= t_start;
            tx_abort_q <= t_can0 && tx_act_q;
            if (t_start) begin
                tx_page_q <= tq_pg_q[2:0];
            end
        end
    end

    // wake-up sequencer writes the pattern then the node id
    always_ff @(posedge i_sys_clk) begin
        if (core_rst) begin
            nid_q       <= tncr_pkg::NID_IDLE;
            ram_we_q    <= 1'b0;
            ram_addr_q  <= 11'h0;
            ram_wdata_q <= 8'h0;
        end else if (i_ce) begin
            ram_we_q <= 1'b0;
            case (nid_q)
                tncr_pkg::NID_IDLE: begin
                    if (wr_node) begin
                        nid_q <= tncr_pkg::NID_WR0;
                    end
                end
                tncr_pkg::NID_WR0: begin
                    ram_we_q    <= 1'b1;
                    ram_addr_q  <= tncr_pkg::NID_ADDR0;
                    ram_wdata_q <= tncr_pkg::NID_PATTERN;
                    nid_q       <= tncr_pkg::NID_WR1;
                end
                tncr_pkg::NID_WR1: begin
                    ram_we_q    <= 1'b1;
                    ram_addr_q  <= tncr_pkg::NID_ADDR1;
                    ram_wdata_q <= node_q;
                    nid_q       <= tncr_pkg::NID_IDLE;
                end
                default: begin
                    nid_q <= tncr_pkg::NID_IDLE;
                end
            endcase
        end
    end

    // outputs
    assign o_hrdata     = rd_q;
    assign o_hreadyout  = i_ce;
    assign o_hresp      = 1'b0;
    assign o_tx_start   = tx_start_q;
    assign o_tx_abort   = tx_abort_q;
    assign o_tx_page    = tx_page_q;
    assign o_tx_enable  = cfg_q[tncr_pkg::CFG_TXEN_BIT] && !core_rst;
    assign o_rx_armed   = rq_v_q[0];
    assign o_rx_page    = rq_pg_q[2:0];
    assign o_ram_we     = ram_we_q;
    assign o_ram_addr   = ram_addr_q;
    assign o_ram_wdata  = ram_wdata_q;
    assign o_core_rst   = core_rst;
    assign o_core_awake = (node_q != 8'h0) && !core_rst;
    assign o_irq        = irq_q;
endmodule : tncr_top

// ### hdl/tncr_pkg.sv
// constants, command codes and queue helper for the token node command chaining and reset block
package tncr_pkg;
    // register byte offsets on the bus
    localparam logic [7:0] REG_CFG    = 8'h00;
    localparam logic [7:0] REG_CMD    = 8'h04;
    localparam logic [7:0] REG_STAT   = 8'h08;
    localparam logic [7:0] REG_MASK   = 8'h0c;
    localparam logic [7:0] REG_SETUP  = 8'h10;
    localparam logic [7:0] REG_NODEID = 8'h14;
    localparam logic [7:0] REG_QUEUE  = 8'h18;
    localparam logic [7:0] REG_RESPG  = 8'h1c;
    // configuration fields and reset values
    localparam int CFG_TXEN_BIT  = 5;
    localparam int CFG_CHAIN_BIT = 6;
    localparam int CFG_SRST_BIT  = 7;
    localparam logic [7:0] CFG_RST   = 8'h00;
    localparam logic [7:0] SETUP_RST = 8'h00;
    localparam logic [7:0] NODE_RST  = 8'h00;
    localparam logic [1:0] MASK_RST  = 2'h0;
    // command register layout and codes
    localparam int CMD_CODE_LSB = 0;
    localparam int CMD_PAGE_LSB = 4;
    localparam logic [2:0] CMD_TX_EN   = 3'h1;
    localparam logic [2:0] CMD_RX_EN   = 3'h2;
    localparam logic [2:0] CMD_TX_DIS  = 3'h3;
    localparam logic [2:0] CMD_RX_DIS  = 3'h4;
    localparam logic [2:0] CMD_CLR_TXI = 3'h5;
    localparam logic [2:0] CMD_CLR_RXI = 3'h6;
    // status bit positions
    localparam int ST_TX_FREE = 0;
    localparam int ST_TX_ACK  = 1;
    localparam int ST_RX_IDLE = 2;
    localparam int ST_TX_DONE = 3;
    localparam int ST_RX_DONE = 4;
    localparam int ST_CHAIN   = 5;
    localparam int ST_AWAKE   = 6;
    // mask bit positions
    localparam int MASK_TX = 0;
    localparam int MASK_RX = 1;
    // queue register field positions
    localparam int QF_TXQ  = 0;
    localparam int QF_RXQ  = 2;
    localparam int QF_TXR  = 4;
    localparam int QF_RXR  = 6;
    localparam int QF_TXPG = 8;
    localparam int QF_RXPG = 12;
    // node identifier wake-up pattern and ram addresses
    localparam logic [7:0]  NID_PATTERN = 8'hd1;
    localparam logic [10:0] NID_ADDR0   = 11'h000;
    localparam logic [10:0] NID_ADDR1   = 11'h001;
    // timing
    localparam int CLK_NS      = 100;
    localparam int IRQ_GAP_NS  = 200;
    localparam int IRQ_GAP_CYC = (IRQ_GAP_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [1:0] GAP_LOAD = 2'(IRQ_GAP_CYC);
    localparam int HWRST_PERIODS = 5;
    localparam logic [2:0] HWRST_CNT = 3'(HWRST_PERIODS);
    // ahb transfer type
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    // wake-up write sequencer states
    typedef enum logic [2:0] {
        NID_IDLE = 3'b001,
        NID_WR0  = 3'b010,
        NID_WR1  = 3'b100
    } tncr_nid_e;

    // two-entry queue: drop entries not kept, close the gap, then append
    function automatic logic [7:0] tncr_q_next(input logic [1:0] keep, input logic [5:0] pl,
                                               input logic push, input logic [2:0] ppl);
        logic [1:0] v;
        logic [5:0] p;
        v = 2'h0;
        p = pl;
        if (keep[0]) begin
            v = {keep[1], 1'b1};
        end else if (keep[1]) begin
            v[0] = 1'b1;
            p[2:0] = pl[5:3];
        end
        if (push && !v[0]) begin
            v[0] = 1'b1;
            p[2:0] = ppl;
        end else if (push && !v[1]) begin
            v[1] = 1'b1;
            p[5:3] = ppl;
        end
        return {v, p};
    endfunction : tncr_q_next
endpackage : tncr_pkg

// ### hdl/tncr_rst_filter.sv
// glitch filter for the hardware reset pin
`timescale 1ns/10ps
module tncr_rst_filter (
    // clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_srst,
    input  wire logic i_ce,
    // pin and filtered reset
    input  wire logic i_hw_reset_n,
    output logic      o_hw_rst
);
    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    logic       rst_q;
    logic       rst_d;

    // count consecutive low samples, drop on any high sample
    assign cnt_d = i_hw_reset_n ? 3'h0 :
                   (cnt_q == tncr_pkg::HWRST_CNT) ? cnt_q : cnt_q + 3'h1;
    assign rst_d = !i_hw_reset_n && (cnt_d == tncr_pkg::HWRST_CNT);

    // counter and reset flop
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            cnt_q <= 3'h0;
            rst_q <= 1'b0;
        end else if (i_ce) begin
            cnt_q <= cnt_d;
            rst_q <= rst_d;
        end
    end

    assign o_hw_rst = rst_q;
endmodule : tncr_rst_filter

// ### verif/tncr_asserts.sv
// port checker for the command chaining and reset block
`timescale 1ns/10ps
module tncr_asserts (
    // watched ports
    input wire logic        i_sys_clk,
    input wire logic        i_srst,
    input wire logic        i_ce,
    input wire logic        i_hw_reset_n,
    input wire logic        i_token,
    input wire logic        o_tx_start,
    input wire logic        o_tx_enable,
    input wire logic        o_ram_we,
    input wire logic [10:0] o_ram_addr,
    input wire logic [7:0]  o_ram_wdata,
    input wire logic        o_core_rst,
    input wire logic        o_core_awake,
    input wire logic        o_irq
);
    // one clock domain, cleared by the sync reset
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_srst);
    // wake-up ram write steps
    sequence s_wr0;
        o_ram_wdata == tncr_pkg::NID_PATTERN;
    endsequence
    sequence s_wr1;
        o_ram_we && o_ram_addr == tncr_pkg::NID_ADDR1;
    endsequence
    // properties
    property p_nid; o_ram_we && o_ram_addr == tncr_pkg::NID_ADDR0 |-> s_wr0 ##1 s_wr1; endproperty
    property p_rst_irq; o_core_rst |=> !o_irq; endproperty
    property p_rst_txen; o_core_rst |-> !o_tx_enable ##1 !o_core_awake; endproperty
    property p_gap; $fell(o_irq) |=> !o_irq; endproperty
    property p_start; o_tx_start |-> $past(i_token); endproperty
    property p_pulse; o_tx_start |=> !o_tx_start; endproperty
    property p_pin; (i_ce && !i_hw_reset_n) [*5] |=> o_core_rst; endproperty
    property p_ram_quiet; o_core_rst |=> !o_ram_we; endproperty
    a_nid: assert property (p_nid) else $error("wake-up writes wrong");
    a_rst_irq: assert property (p_rst_irq) else $error("irq after reset");
    a_rst_txen: assert property (p_rst_txen) else $error("enabled in reset");
    a_gap: assert property (p_gap) else $error("irq gap too short");
    a_start: assert property (p_start) else $error("start without token");
    a_pulse: assert property (p_pulse) else $error("start too long");
    a_pin: assert property (p_pin) else $error("pin reset missed");
    a_ram_quiet: assert property (p_ram_quiet) else $error("ram write in reset");
endmodule : tncr_asserts
bind tncr_top tncr_asserts tncr_asserts_inst (.i_sys_clk, .i_srst, .i_ce, .i_hw_reset_n, .i_token, .o_tx_start,
    .o_tx_enable, .o_ram_we, .o_ram_addr, .o_ram_wdata, .o_core_rst, .o_core_awake, .o_irq);

// ### verif/tncr_host_model.sv
// bus master model of the host controller
`timescale 1ns/10ps
module tncr_host_model (
    // answer from the slave
    input  wire logic        i_sys_clk,
    input  wire logic        i_hready,
    input  wire logic [31:0] i_hrdata,
    // request
    output logic             o_hsel = 1'b0,
    output logic [31:0]      o_haddr = 32'h0,
    output logic [1:0]       o_htrans = 2'h0,
    output logic             o_hwrite = 1'b0,
    output logic [2:0]       o_hsize = 3'h2,
    output logic [31:0]      o_hwdata = 32'h0,
    output logic             o_hang = 1'b0
);
    // single word transfer, each wait bounded
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        o_hsel <= 1'b1;
        o_htrans <= tncr_pkg::HTRANS_NONSEQ;
        o_haddr <= {24'h0, a};
        o_hwrite <= w;
        do @(posedge i_sys_clk); while (!i_hready && ++n < 20);
        o_hsel <= 1'b0;
        o_htrans <= 2'h0;
        o_haddr <= ~o_haddr; // released address does not linger
        o_hwdata <= wd;
        do @(posedge i_sys_clk); while (!i_hready && ++n < 40);
        rd = i_hrdata;
        o_hwdata <= ~wd;
        if (n >= 20) o_hang <= 1'b1;
    endtask : xfer
endmodule : tncr_host_model

// ### verif/tncr_top_tb.sv
// self-checking bench for the command chaining and reset block
`timescale 1ns/10ps
module tncr_top_tb;
    // stimulus and design outputs
    logic        i_sys_clk = 1'b0, i_srst = 1'b1, i_ce = 1'b1, i_hw_reset_n = 1'b1, i_tx_acked = 1'b0;
    logic        i_token = 1'b0, i_tx_done = 1'b0, i_rx_start = 1'b0, i_rx_done = 1'b0;
    logic        i_hsel, i_hwrite, i_hready, o_hreadyout, o_hresp, o_tx_start, o_tx_abort, o_tx_enable;
    logic        o_rx_armed, o_ram_we, o_core_rst, o_core_awake, o_irq, hang;
    logic [31:0] i_haddr, i_hwdata, o_hrdata, rd;
    logic [1:0]  i_htrans;
    logic [2:0]  i_hsize, o_tx_page, o_rx_page;
    logic [10:0] o_ram_addr;
    logic [7:0]  o_ram_wdata;
    logic [18:0] ram_log[$];
    logic [2:0]  start_log[$];
    int          err_total = 0;
    int          check_count = 0;
    int          abort_count = 0;
    assign i_hready = o_hreadyout;
    tncr_top tncr_top_inst (.*);
    tncr_host_model tncr_host_model_inst (.i_sys_clk, .i_hready, .i_hrdata(o_hrdata), .o_hsel(i_hsel),
        .o_haddr(i_haddr), .o_htrans(i_htrans), .o_hwrite(i_hwrite), .o_hsize(i_hsize), .o_hwdata(i_hwdata),
        .o_hang(hang));
    // clock
    initial forever #50 i_sys_clk = ~i_sys_clk;
    // log ram writes and transmit starts
    always @(posedge i_sys_clk) begin
        if (o_ram_we) ram_log.push_back({o_ram_addr, o_ram_wdata});
        if (o_tx_start) start_log.push_back(o_tx_page);
        if (o_tx_abort) abort_count++;
    end
    // a stuck bus ends the run
    always @(posedge hang) begin
        err_total++;
        finish_test();
    end
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        tncr_host_model_inst.xfer(a, 1'b1, d, rd);
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        tncr_host_model_inst.xfer(a, 1'b0, 32'h0, rd);
        chk(rd & m, e);
    endtask : rdchk
    task automatic cmd(input logic [2:0] code, input logic [2:0] pg);
        wr(tncr_pkg::REG_CMD, {25'h0, pg, 1'b0, code});
    endtask : cmd
    // one cycle pulse on {token, tx done, rx start, rx done}
    task automatic ev(input logic [3:0] v);
        {i_token, i_tx_done, i_rx_start, i_rx_done} <= v;
        tick(1);
        {i_token, i_tx_done, i_rx_start, i_rx_done} <= 4'h0;
        tick(3);
    endtask : ev
    task automatic t_reset;
        rdchk(tncr_pkg::REG_CFG, 32'hff, 32'h0);
        rdchk(tncr_pkg::REG_STAT, 32'h7f, 32'h05);
        rdchk(8'h20, 32'hffffffff, 32'h0);
        chk({31'h0, o_hresp}, 32'h0);
    endtask : t_reset
    task automatic t_wake;
        wr(tncr_pkg::REG_SETUP, 32'h81);
        wr(tncr_pkg::REG_NODEID, 32'h5a);
        tick(4);
        chk({13'h0, ram_log[0]}, {13'h0, tncr_pkg::NID_ADDR0, tncr_pkg::NID_PATTERN});
        chk({13'h0, ram_log[1]}, {13'h0, tncr_pkg::NID_ADDR1, 8'h5a});
        rdchk(tncr_pkg::REG_STAT, 32'h40, 32'h40);
    endtask : t_wake
    task automatic t_tx;
        wr(tncr_pkg::REG_CFG, 32'h60);
        wr(tncr_pkg::REG_MASK, 32'h1);
        cmd(tncr_pkg::CMD_TX_EN, 3'h3);
        cmd(tncr_pkg::CMD_TX_EN, 3'h5);
        rdchk(tncr_pkg::REG_QUEUE, 32'h3, 32'h3);
        rdchk(tncr_pkg::REG_STAT, 32'h3, 32'h0);
        i_tx_acked <= 1'b1;
        ev(4'h8);
        ev(4'h4);
        ev(4'h8);
        i_tx_acked <= 1'b0;
        ev(4'h4);
        chk({26'h0, start_log[0], start_log[1]}, 32'h1d);
        rdchk(tncr_pkg::REG_STAT, 32'ha, 32'ha);
        chk({31'h0, o_irq}, 32'h1);
        cmd(tncr_pkg::CMD_CLR_TXI, 3'h0);
        tick(6);
        rdchk(tncr_pkg::REG_STAT, 32'ha, 32'h8);
        cmd(tncr_pkg::CMD_CLR_TXI, 3'h0);
        cmd(tncr_pkg::CMD_CLR_TXI, 3'h0);
        tick(3);
        chk({31'h0, o_irq}, 32'h0);
        rdchk(tncr_pkg::REG_QUEUE, 32'hff, 32'h0);
        cmd(tncr_pkg::CMD_TX_EN, 3'h6);
        ev(4'h8);
        cmd(tncr_pkg::CMD_TX_DIS, 3'h0);
        rdchk(tncr_pkg::REG_QUEUE, 32'hff, 32'h0);
        chk({29'h0, start_log[2]}, 32'h6);
        chk(32'(abort_count), 32'h1);
    endtask : t_tx
    task automatic t_rx;
        wr(tncr_pkg::REG_MASK, 32'h2);
        cmd(tncr_pkg::CMD_RX_EN, 3'h2);
        cmd(tncr_pkg::CMD_RX_EN, 3'h4);
        cmd(tncr_pkg::CMD_RX_DIS, 3'h0);
        rdchk(tncr_pkg::REG_QUEUE, 32'h700c, 32'h4004);
        chk({28'h0, o_rx_armed, o_rx_page}, 32'hc);
        ev(4'h2);
        ev(4'h1);
        rdchk(tncr_pkg::REG_STAT, 32'h10, 32'h10);
        rdchk(tncr_pkg::REG_RESPG, 32'h7, 32'h4);
        chk({31'h0, o_irq}, 32'h1);
        cmd(tncr_pkg::CMD_CLR_RXI, 3'h0);
        tick(3);
        chk({31'h0, o_irq}, 32'h0);
    endtask : t_rx
    task automatic t_rst;
        wr(tncr_pkg::REG_CFG, 32'he0);
        tick(1);
        chk({30'h0, o_core_rst, o_tx_enable}, 32'h2);
        rdchk(tncr_pkg::REG_CFG, 32'hff, 32'he0);
        rdchk(tncr_pkg::REG_SETUP, 32'hff, 32'h81);
        wr(tncr_pkg::REG_CFG, 32'h60);
        i_hw_reset_n <= 1'b0;
        tick(4);
        i_hw_reset_n <= 1'b1;
        tick(2);
        rdchk(tncr_pkg::REG_CFG, 32'hff, 32'h60);
        i_hw_reset_n <= 1'b0;
        tick(7);
        chk({31'h0, o_core_rst}, 32'h1);
        i_hw_reset_n <= 1'b1;
        tick(3);
        rdchk(tncr_pkg::REG_CFG, 32'hff, 32'h0);
        rdchk(tncr_pkg::REG_SETUP, 32'hff, 32'h0);
    endtask : t_rst
    // reset, scenarios, verdict
    initial begin
        tick(16);
        i_srst <= 1'b0;
        tick(1);
        t_reset();
        t_wake();
        t_tx();
        t_rx();
        t_rst();
        finish_test();
    end
endmodule : tncr_top_tb
